// file: core/csm_pkg.sv
// Shared constants, enumerations and state carriers of the clock source module.
// Assumes a single 125 MHz system clock and a 32-bit Avalon-MM register slave.
package csm_pkg;

  // Register byte offsets
  localparam logic [3:0] CSM_OFS_CTL1 = 4'h0;
  localparam logic [3:0] CSM_OFS_CTL2 = 4'h4;
  localparam logic [3:0] CSM_OFS_TRIM = 4'h8;
  localparam logic [3:0] CSM_OFS_STAT = 4'hC;

  // Field positions of clock_source_control_one
  localparam int CSM_CTL1_SRC_LSB = 7'h06;
  localparam int CSM_CTL1_REFERENCE_DIVIDER_FIELD_LSB = 7'h03;
  localparam int CSM_CTL1_REFSEL_BIT = 7'h02;
  localparam int CSM_CTL1_INTERNAL_REF_ENABLE_BIT_BIT = 7'h01;
  localparam int CSM_CTL1_IRSTEN_BIT = 7'h00;
  // Field positions of the second control register
  localparam int CSM_CTL2_BUS_DIVIDER_FIELD_LSB = 7'h06;
  localparam int CSM_CTL2_LP_BIT = 7'h03;
  localparam int CSM_CTL2_ERCLKEN_BIT = 7'h01;
  localparam int CSM_CTL2_ERSTEN_BIT = 7'h00;
  // Field positions of the status register
  localparam int CSM_STAT_MODE_LSB = 7'h02;
  localparam int CSM_STAT_FTRIM_BIT = 7'h00;

  // Reset values; trim midpoint is an arbitrary neutral value
  localparam logic [7:0] CSM_CTL1_RST = 8'h04;
  localparam logic [7:0] CSM_CTL2_RST = 8'h40;
  localparam logic [7:0] CSM_TRIM_RST = 8'h80;

  // Timing: system clock rate and highest reference rate the loop accepts
  localparam int CSM_CLK_KHZ = 125000;
  localparam int CSM_REF_MAX_KHZ = 5000;
  // Samples per reference half period at the highest reference rate
  localparam int CSM_REF_HALF_CYCLES = CSM_CLK_KHZ / (2 * CSM_REF_MAX_KHZ);

  typedef enum logic [1:0] {
    CSM_SRC_LOOP = 2'b00,
    CSM_SRC_INT = 2'b01,
    CSM_SRC_EXT = 2'b10
  } csm_src_t;

  typedef enum logic [2:0] {
    CSM_MODE_FEI = 3'b000,
    CSM_MODE_FEE = 3'b001,
    CSM_MODE_FBI = 3'b010,
    CSM_MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER_MODE = 3'b011,
    CSM_MODE_FBE = 3'b100,
    CSM_MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER_MODE = 3'b101,
    CSM_MODE_STOP = 3'b110
  } csm_mode_t;

  typedef enum logic [1:0] {
    CSM_SW_RUN = 2'b00,
    CSM_SW_DRAIN = 2'b01,
    CSM_SW_WAIT = 2'b10
  } csm_sw_t;

  // Sampled clock level with its edges
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } csm_edges_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } csm_sync_t;

  typedef struct packed {
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] trim;
    logic ftrim;
    logic ack;
    logic [31:0] rdata;
    csm_sw_t sw_state;
    csm_src_t cur_src;
    csm_src_t tgt_src;
    logic [6:0] div_cnt;
    logic sys_clk;
    logic bus_clk;
    logic dbg_clk;
    logic [6:0] ref_cnt;
    logic ref_tick;
    logic irclk;
    csm_mode_t mode;
    csm_mode_t pre_stop_mode;
    logic loop_en;
    logic ref_int;
    logic int_ref_en;
    logic ext_ref_en;
  } csm_state_t;

  localparam csm_state_t CSM_STATE_RST = '{
    ctl1: CSM_CTL1_RST, ctl2: CSM_CTL2_RST, trim: CSM_TRIM_RST,
    sw_state: CSM_SW_RUN, cur_src: CSM_SRC_LOOP, tgt_src: CSM_SRC_LOOP,
    mode: CSM_MODE_FEI, pre_stop_mode: CSM_MODE_FEI,
    loop_en: 1'b1, ref_int: 1'b1, int_ref_en: 1'b1, default: '0};

endpackage : csm_pkg

// file: core/csm_edge_sync.sv
// Two-flop synchroniser with edge detection for one free-running clock pin.
// Assumes the sampled clock is well below half the system clock rate.
`timescale 1ns/100ps
`default_nettype none
module csm_edge_sync
  import csm_pkg::*;
(
  input wire logic clk_i,           // System clock
  input wire logic rst_i,           // Asynchronous reset, active high
  input wire logic async_i,         // Clock from outside this domain
  output var csm_edges_t edges_o    // Synchronised level and edges
);

  csm_sync_t st;
  csm_sync_t next_st;

  // Only s2 and s3 are looked at; s1 may be metastable
  always_comb
  begin
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  // Edges taken between the second and third flop
  assign edges_o.level = st.s2;
  assign edges_o.rise = st.s2 & ~st.s3;
  assign edges_o.fall = ~st.s2 & st.s3;

endmodule : csm_edge_sync
`default_nettype wire

// file: core/csm_clock_source.sv
// Clock source control: mode selection, loop control, reference and bus dividers,
// glitch-free system clock switching and the Avalon-MM register slave.
// Assumes reference and oscillator clocks arrive as pins and are oversampled on clk_i.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - System clock output runs at twice the bus clock frequency.
// - Control register one reads ones in bits one and two.
// - Debug clock is the controlled oscillator output divided by two.
// - Reset leaves the block in loop-engaged internal mode.
// - Engaged internal: loop drives system clock, internal reference, debug clock on.
// - Engaged external: loop drives system clock, external reference, debug clock on.
// - Bypassed internal: loop runs on internal reference, system from internal.
// - Bypassed internal low power: loop off, internal reference, no debug clock.
// - Bypassed external: loop runs on external reference, system from external.
// - Bypassed external low power: loop off, external reference, no debug clock.
// - Stop: loop off, no system or debug clock, references per stop enables.
// - Source select 00 loop, 01 internal, 10 external, 11 acts as 00.
// - Reference divider divides the loop reference by two to the field value.
// - In engaged modes reference select set locks to internal, clear locks to external.
// - Internal reference enable gates the internal reference clock output.
// - Internal reference keeps running in stop when stop enable allows it.
// - Loop accepts internal or external references up to 5 MHz.
// - Internal reference period is adjusted by nine binary-weighted trim bits.
// - Bus divider divides by 1, 2, 4 or 8, reset code 01.
// - Mode status reports the source only after the switchover has completed.
// - Writing source 00 and reference select 1 enters engaged internal mode.
module csm_clock_source
  import csm_pkg::*;
(
  input wire logic clk_i,                        // System clock, 125 MHz
  input wire logic rst_i,                        // Asynchronous reset, active high
  input wire logic [3:0] avs_address_i,          // Register byte address
  input wire logic avs_read_i,                   // Read request
  input wire logic avs_write_i,                  // Write request
  input wire logic [31:0] avs_writedata_i,       // Write data
  input wire logic [3:0] avs_byteenable_i,       // Byte lanes, lane 0 holds data
  output logic [31:0] avs_readdata_o,            // Read data
  output logic avs_waitrequest_o,                // Slave not ready
  input wire logic stop_i,                       // Stop mode request from the core
  input wire logic int_ref_clk_i,                // Internal reference oscillator
  input wire logic ext_ref_clk_i,                // External reference clock
  input wire logic dco_clk_i,                    // Controlled oscillator output
  output logic system_clock_output_o,            // Selected and divided system clock
  output logic bus_clk_o,                        // Bus clock, half the system clock
  output logic debug_clk_o,                      // Debug controller clock
  output logic gated_internal_ref_clock_o,       // Gated internal reference
  output logic ref_div_tick_o,                   // One pulse per divided reference period
  output logic loop_enable_o,                    // Loop running
  output logic loop_ref_internal_o,              // Loop locked to internal reference
  output logic int_ref_enable_o,                 // Internal reference oscillator on
  output logic ext_ref_enable_o,                 // External reference on
  output logic [8:0] trim_o,                     // Internal reference period trim
  output logic [1:0] clock_mode_status_o,        // Active system clock source
  output logic [2:0] mode_o                      // Current operating mode
);

  csm_state_t st;
  csm_state_t n;
  csm_edges_t int_e;
  csm_edges_t ext_e;
  csm_edges_t dco_e;
  csm_edges_t cur_e;
  csm_edges_t tgt_e;
  csm_src_t req_src;
  csm_mode_t mode;
  logic [6:0] rmask;
  logic [6:0] bmask;
  logic ref_rise;
  logic run_div;
  logic bus_req;

  // Mask of low counter bits for a divide by two to the code
  function automatic logic [6:0] csm_div_mask(input logic [2:0] code);
    csm_div_mask = ~(7'h7F << code);
  endfunction : csm_div_mask

  // Reserved source code falls back to the loop output
  function automatic csm_src_t csm_src_decode(input logic [1:0] code);
    case (code)
      2'b01: csm_src_decode = CSM_SRC_INT;
      2'b10: csm_src_decode = CSM_SRC_EXT;
      default: csm_src_decode = CSM_SRC_LOOP;
    endcase
  endfunction : csm_src_decode

  // Edges of the clock that feeds a given source
  function automatic csm_edges_t csm_pick(input csm_src_t src, input csm_edges_t lp,
                                          input csm_edges_t ir, input csm_edges_t er);
    case (src)
      CSM_SRC_INT: csm_pick = ir;
      CSM_SRC_EXT: csm_pick = er;
      default: csm_pick = lp;
    endcase
  endfunction : csm_pick

  function automatic logic csm_is_int(input csm_mode_t m);
    csm_is_int = (m == CSM_MODE_FEI) || (m == CSM_MODE_FBI) || (m == CSM_MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER_MODE);
  endfunction : csm_is_int

  function automatic logic csm_is_ext(input csm_mode_t m);
    csm_is_ext = (m == CSM_MODE_FEE) || (m == CSM_MODE_FBE) || (m == CSM_MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER_MODE);
  endfunction : csm_is_ext

  // Each clock pin is oversampled; 5 MHz leaves ample samples per phase
  csm_edge_sync u_int_sync (.clk_i(clk_i), .rst_i(rst_i), .async_i(int_ref_clk_i),
                            .edges_o(int_e));
  csm_edge_sync u_ext_sync (.clk_i(clk_i), .rst_i(rst_i), .async_i(ext_ref_clk_i),
                            .edges_o(ext_e));
  csm_edge_sync u_dco_sync (.clk_i(clk_i), .rst_i(rst_i), .async_i(dco_clk_i),
                            .edges_o(dco_e));

  // Handshake: one wait cycle, then the answer
  assign bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~st.ack;

  // Next-state logic for the whole block
  always_comb
  begin
    n = st;
    n.ref_tick = 1'b0;
    run_div = 1'b0;
    req_src = csm_src_decode(st.ctl1[CSM_CTL1_SRC_LSB +: 2]);
    rmask = csm_div_mask(st.ctl1[CSM_CTL1_REFERENCE_DIVIDER_FIELD_LSB +: 3]);
    bmask = csm_div_mask({1'b0, st.ctl2[CSM_CTL2_BUS_DIVIDER_FIELD_LSB +: 2]});
    cur_e = csm_pick(st.cur_src, dco_e, int_e, ext_e);
    tgt_e = csm_pick(st.tgt_src, dco_e, int_e, ext_e);

    // Mode from source select, reference select and low power
    if (stop_i)
      mode = CSM_MODE_STOP;
    else
    begin
      case (req_src)
        CSM_SRC_INT: mode = st.ctl2[CSM_CTL2_LP_BIT] ? CSM_MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER_MODE : CSM_MODE_FBI;
        CSM_SRC_EXT: mode = st.ctl2[CSM_CTL2_LP_BIT] ? CSM_MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER_MODE : CSM_MODE_FBE;
        default: mode = st.ctl1[CSM_CTL1_REFSEL_BIT] ? CSM_MODE_FEI : CSM_MODE_FEE;
      endcase
    end
    n.mode = mode;
    if (mode != CSM_MODE_STOP)
      n.pre_stop_mode = mode;

    // Loop runs in engaged and plain bypassed modes only
    n.loop_en = (mode == CSM_MODE_FEI) || (mode == CSM_MODE_FEE) ||
                (mode == CSM_MODE_FBI) || (mode == CSM_MODE_FBE);
    // Bypassed modes lock to the reference they pass through
    case (mode)
      CSM_MODE_FBI, CSM_MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER_MODE: n.ref_int = 1'b1;
      CSM_MODE_FBE, CSM_MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER_MODE: n.ref_int = 1'b0;
      default: n.ref_int = st.ctl1[CSM_CTL1_REFSEL_BIT];
    endcase

    // Reference oscillators: enables decide their life in stop
    if (mode == CSM_MODE_STOP)
    begin
      n.int_ref_en = st.ctl1[CSM_CTL1_IRSTEN_BIT] &
                     (st.ctl1[CSM_CTL1_INTERNAL_REF_ENABLE_BIT_BIT] | csm_is_int(st.pre_stop_mode));
      n.ext_ref_en = st.ctl2[CSM_CTL2_ERSTEN_BIT] &
                     (st.ctl2[CSM_CTL2_ERCLKEN_BIT] | csm_is_ext(st.pre_stop_mode));
    end
    else
    begin
      n.int_ref_en = st.ctl1[CSM_CTL1_INTERNAL_REF_ENABLE_BIT_BIT] | csm_is_int(mode) | n.ref_int;
      n.ext_ref_en = st.ctl2[CSM_CTL2_ERCLKEN_BIT] | csm_is_ext(mode) | ~n.ref_int;
    end
    n.irclk = st.ctl1[CSM_CTL1_INTERNAL_REF_ENABLE_BIT_BIT] & n.int_ref_en & int_e.level;

    // Reference divider feeding the loop comparator
    ref_rise = n.ref_int ? int_e.rise : ext_e.rise;
    if (!n.loop_en)
      n.ref_cnt = 7'h00;
    else if (ref_rise)
    begin
      if ((st.ref_cnt & rmask) == rmask)
      begin
        n.ref_cnt = 7'h00;
        n.ref_tick = 1'b1;
      end
      else
        n.ref_cnt = 7'(st.ref_cnt + 7'h01);
    end

    // Debug clock toggles on each oscillator rise while the loop runs
    if (!n.loop_en)
      n.dbg_clk = 1'b0;
    else if (dco_e.rise)
      n.dbg_clk = ~st.dbg_clk;

    // Switchover: old clock must reach a low phase, new clock a rise
    if (mode == CSM_MODE_STOP)
      n.sys_clk = 1'b0;
    else
    begin
      case (st.sw_state)
        CSM_SW_RUN:
        begin
          run_div = 1'b1;
          if (req_src != st.cur_src)
          begin
            n.tgt_src = req_src;
            n.sw_state = CSM_SW_DRAIN;
          end
        end
        CSM_SW_DRAIN:
        begin
          if (!st.sys_clk && cur_e.fall)
            n.sw_state = CSM_SW_WAIT;
          else
            run_div = 1'b1;
        end
        CSM_SW_WAIT:
        begin
          // Output held low until the new clock is seen rising
          if (tgt_e.rise)
          begin
            n.cur_src = st.tgt_src;
            n.div_cnt = 7'h00;
            n.sw_state = CSM_SW_RUN;
          end
        end
        default: n.sw_state = CSM_SW_RUN;
      endcase
    end

    // Bus divider counts both edges so that code 00 passes the clock unchanged
    if (run_div && (cur_e.rise || cur_e.fall))
    begin
      if ((st.div_cnt & bmask) == bmask)
      begin
        n.div_cnt = 7'h00;
        n.sys_clk = ~st.sys_clk;
        if (!st.sys_clk)
          n.bus_clk = ~st.bus_clk;
      end
      else
        n.div_cnt = 7'(st.div_cnt + 7'h01);
    end

    // Register slave: read data captured in the wait cycle
    n.ack = bus_req & ~st.ack;
    if (avs_read_i && !st.ack)
    begin
      case (avs_address_i)
        CSM_OFS_CTL1: n.rdata = {24'h00_0000, st.ctl1[7:3], 2'b11,
                                 st.ctl1[CSM_CTL1_IRSTEN_BIT]};
        CSM_OFS_CTL2: n.rdata = {24'h00_0000, st.ctl2};
        CSM_OFS_TRIM: n.rdata = {24'h00_0000, st.trim};
        CSM_OFS_STAT: n.rdata = {28'h000_0000, st.cur_src, 1'b0, st.ftrim};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    // Writes land at the edge where waitrequest is low
    if (avs_write_i && st.ack && avs_byteenable_i[0])
    begin
      case (avs_address_i)
        CSM_OFS_CTL1: n.ctl1 = avs_writedata_i[7:0];
        CSM_OFS_CTL2: n.ctl2 = avs_writedata_i[7:0];
        CSM_OFS_TRIM: n.trim = avs_writedata_i[7:0];
        CSM_OFS_STAT: n.ftrim = avs_writedata_i[CSM_STAT_FTRIM_BIT];
        default: n.ftrim = st.ftrim;
      endcase
    end
  end

  // Reset state is engaged internal with the loop running
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= CSM_STATE_RST;
    else
      st <= n;
  end

  // All data outputs straight from state
  assign avs_readdata_o = st.rdata;
  assign system_clock_output_o = st.sys_clk;
  assign bus_clk_o = st.bus_clk;
  assign debug_clk_o = st.dbg_clk;
  assign gated_internal_ref_clock_o = st.irclk;
  assign ref_div_tick_o = st.ref_tick;
  assign loop_enable_o = st.loop_en;
  assign loop_ref_internal_o = st.ref_int;
  assign int_ref_enable_o = st.int_ref_en;
  assign ext_ref_enable_o = st.ext_ref_en;
  assign trim_o = {st.trim, st.ftrim};
  assign clock_mode_status_o = st.cur_src;
  assign mode_o = st.mode;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_bus_half_sys: assert property ($changed(st.bus_clk) |-> $rose(st.sys_clk))
    else $error("bus clock moved without a system clock rise");
  chk_ctl1_ones_read: assert property ((avs_read_i && !avs_waitrequest_o &&
    avs_address_i == CSM_OFS_CTL1) |-> avs_readdata_o[2:1] == 2'b11)
    else $error("control one bits 1 and 2 not read as one");
  chk_dbg_from_dco: assert property ($rose(st.dbg_clk) |-> $past(dco_e.rise))
    else $error("debug clock rose without oscillator edge");
  chk_reset_fei: assert property (disable iff (1'b0) $fell(rst_i) |->
    st.mode == CSM_MODE_FEI && st.loop_en)
    else $error("reset did not leave engaged internal mode");
  chk_fei_loop: assert property (st.mode == CSM_MODE_FEI |-> st.loop_en && st.ref_int)
    else $error("engaged internal mode misconfigured");
  chk_fee_loop: assert property (st.mode == CSM_MODE_FEE |-> st.loop_en && !st.ref_int)
    else $error("engaged external mode misconfigured");
  chk_fbi_loop: assert property (st.mode == CSM_MODE_FBI |-> st.loop_en && st.ref_int)
    else $error("bypassed internal mode misconfigured");
  chk_loop_bypassed_internal_low_power_mode_off: assert property (st.mode == CSM_MODE_LOOP_BYPASSED_INTERNAL_LOW_POWER_MODE |-> !st.loop_en && !st.dbg_clk)
    else $error("internal low power left loop on");
  chk_fbe_loop: assert property (st.mode == CSM_MODE_FBE |-> st.loop_en && !st.ref_int)
    else $error("bypassed external mode misconfigured");
  chk_loop_bypassed_external_low_power_mode_off: assert property (st.mode == CSM_MODE_LOOP_BYPASSED_EXTERNAL_LOW_POWER_MODE |-> !st.loop_en && !st.dbg_clk)
    else $error("external low power left loop on");
  chk_stop_quiet: assert property (st.mode == CSM_MODE_STOP |->
    !st.sys_clk && !st.dbg_clk && !st.loop_en)
    else $error("clock running in stop");
  chk_status_lags: assert property ($changed(st.cur_src) |->
    $past(st.sw_state) == CSM_SW_WAIT && $past(tgt_e.rise))
    else $error("status changed outside a completed switchover");
  chk_switch_low: assert property (st.sw_state == CSM_SW_WAIT |-> !st.sys_clk)
    else $error("system clock high during switchover");

  cov_to_internal: cover property (st.cur_src == CSM_SRC_LOOP ##1 st.cur_src == CSM_SRC_INT);
  cov_to_external: cover property (st.cur_src == CSM_SRC_INT ##1 st.cur_src == CSM_SRC_EXT);
  cov_stop_entry: cover property (st.mode != CSM_MODE_STOP ##1 st.mode == CSM_MODE_STOP);
  cov_ref_tick: cover property (st.ref_tick && st.ctl1[5:3] == 3'b111);

endmodule : csm_clock_source
`default_nettype wire

// file: tb/csm_osc_model.sv
// Oscillator pins that feed the clock source block from outside its domain.
// Assumes the enables come from the block; a stopped oscillator rests low.
`timescale 1ns/100ps
`default_nettype none
module csm_osc_model
(
  input wire logic int_en_i, // Internal oscillator enable
  input wire logic ext_en_i, // External oscillator enable
  output logic int_clk_o,    // Internal reference pin
  output logic ext_clk_o,    // External reference pin
  output logic osc_clk_o     // Loop oscillator pin
);
  logic i_run = 1'b0;
  logic e_run = 1'b0;
  // References stay below the 5 MHz the loop accepts; phases far above three system clocks
  // Internal runs at 2 MHz so that divide by 64 lands at 31.25 kHz
  initial forever #250 i_run = ~i_run;
  initial forever #310 e_run = ~e_run;
  initial osc_clk_o = 1'b0;
  initial forever #29 osc_clk_o = ~osc_clk_o;
  // A disabled oscillator gives no edges, as real hardware would
  assign int_clk_o = i_run & int_en_i;
  assign ext_clk_o = e_run & ext_en_i;
endmodule : csm_osc_model
`default_nettype wire

// file: tb/fll_clock_source_mode_control_test.sv
// Self-checking bench of the clock source block: registers, modes, dividers, stop.
// Assumes the oscillator model alone drives the clock pins.
`timescale 1ns/100ps
`default_nettype none
module fll_clock_source_mode_control_test import csm_pkg::*;;
  logic clk_i, rst_i, avs_read_i, avs_write_i, stop_i;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic avs_waitrequest_o, sys_o, bus_o, dbg_o, girc_o, tick_o;
  logic loop_en_o, ref_int_o, int_en_o, ext_en_o, int_clk, ext_clk, osc_clk;
  logic [8:0] trim_o;
  logic [1:0] stat_o;
  logic [2:0] mode_o;
  logic [7:0] seed = 8'h5b;
  int miscompares = 0, n_checks = 0, cyc = 0, prev = 0;
  int c_sys, c_bus, c_dbg, c_osc, c_int, c_tick, c_girc;
  int sh[4] = '{CSM_CTL1_RST, CSM_CTL2_RST, CSM_TRIM_RST, 0}; // Register model
  csm_clock_source u_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .stop_i(stop_i), .int_ref_clk_i(int_clk),
    .ext_ref_clk_i(ext_clk), .dco_clk_i(osc_clk), .system_clock_output_o(sys_o),
    .bus_clk_o(bus_o), .debug_clk_o(dbg_o), .gated_internal_ref_clock_o(girc_o),
    .ref_div_tick_o(tick_o), .loop_enable_o(loop_en_o), .loop_ref_internal_o(ref_int_o),
    .int_ref_enable_o(int_en_o), .ext_ref_enable_o(ext_en_o), .trim_o(trim_o),
    .clock_mode_status_o(stat_o), .mode_o(mode_o));
  csm_osc_model u_osc (.int_en_i(int_en_o), .ext_en_i(ext_en_o), .int_clk_o(int_clk),
    .ext_clk_o(ext_clk), .osc_clk_o(osc_clk));
  // 125 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Edge counters feed the rate comparisons
  always @(posedge sys_o) c_sys++;
  always @(posedge bus_o) c_bus++;
  always @(posedge dbg_o) c_dbg++;
  always @(posedge osc_clk) c_osc++;
  always @(posedge int_clk) c_int++;
  always @(posedge girc_o) c_girc++;
  // Tick counter and hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (tick_o === 1'b1) c_tick++;
    if (cyc == 60000)
    begin
      miscompares++;
      complete_run();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Expected mode from the two control registers
  function automatic logic [2:0] exp_mode(input int c1, input int c2);
    int s;
    s = (c1 >> 6) & 3;
    if (s == 1) return (c2 & 8) ? 3'h3 : 3'h2;
    if (s == 2) return (c2 & 8) ? 3'h5 : 3'h4;
    return (c1 & 4) ? 3'h0 : 3'h1;
  endfunction : exp_mode
  function automatic logic [31:0] exp_rd(input logic [3:0] a);
    int s;
    s = (sh[0] >> 6) & 3;
    case (a)
      CSM_OFS_CTL1: return 32'(sh[0] | 6);
      CSM_OFS_CTL2: return 32'(sh[1]);
      CSM_OFS_TRIM: return 32'(sh[2]);
      CSM_OFS_STAT: return 32'(sh[3] | ((s == 3 ? 0 : s) << 2));
      default: return 32'h0000_0000;
    endcase
  endfunction : exp_rd
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t value %0h expected %0h", $time, got, exp);
      miscompares++;
    end
  endtask : cmp_val
  task automatic cmp_cnt(input int got, input int exp, input int tol);
    n_checks++;
    if (got - exp > tol || exp - got > tol)
    begin
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
      miscompares++;
    end
  endtask : cmp_cnt
  // One Avalon cycle; held until waitrequest is seen low at a falling edge, then through the next rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic be);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h00_0000, d};
    avs_byteenable_i <= {3'h0, be};
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    @(negedge clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n == 20) miscompares++;
    rd = avs_readdata_o;
    @(posedge clk_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (wr && be && a[1:0] == 2'h0 && a[3:2] != 2'h3) sh[a[3:2]] = d;
    if (wr && be && a == CSM_OFS_STAT) sh[3] = d[0];
    @(posedge clk_i); // Idle edge so the next call never re-raises a strobe in this step
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask : wr
  task automatic rd_chk(input logic [3:0] a);
    bus(1'b0, a, 8'h00, 1'b0);
    cmp_val(rd, exp_rd(a));
  endtask : rd_chk
  task automatic measure(input int n);
    repeat (20) @(posedge clk_i);
    {c_sys, c_bus, c_dbg, c_osc, c_int, c_tick, c_girc} = '0;
    repeat (n) @(posedge clk_i);
  endtask : measure
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // Main sequence
  initial
  begin
    {rst_i, stop_i, avs_read_i, avs_write_i} = 4'h8;
    {avs_address_i, avs_byteenable_i, avs_writedata_i} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cmp_val({mode_o, loop_en_o, ref_int_o}, 5'h03);
    rd_chk(CSM_OFS_CTL1);
    rd_chk(CSM_OFS_CTL2);
    rd_chk(CSM_OFS_STAT);
    rd_chk(4'h2);
    bus(1'b1, CSM_OFS_CTL2, 8'hff, 1'b0);
    rd_chk(CSM_OFS_CTL2);
    seed = lfsr(seed);
    wr(CSM_OFS_TRIM, seed);
    wr(CSM_OFS_STAT, 8'h01);
    repeat (2) @(posedge clk_i);
    cmp_val(trim_o, {seed, 1'b1});
    rd_chk(CSM_OFS_TRIM);
    seed = lfsr(seed);
    wr(CSM_OFS_CTL1, seed & 8'h39);
    rd_chk(CSM_OFS_CTL1);
    $display("registers done");
    // Every source code and low-power setting; both oscillators kept on
    for (int i = 0; i < 16; i++)
    begin
      wr(CSM_OFS_CTL2, {2'h1, 2'h0, i[1], 3'h2});
      wr(CSM_OFS_CTL1, {i[3:2], 3'h0, i[0], 2'h2});
      // Status cannot have moved yet: the switchover needs synchronised edges first
      cmp_val(stat_o, prev);
      repeat (2) @(posedge clk_i);
      cmp_val(mode_o, exp_mode(sh[0], sh[1]));
      if (mode_o == 3'h3 || mode_o == 3'h5)
      begin
        measure(200);
        cmp_cnt(c_dbg + loop_en_o, 0, 0);
      end
      else
        cmp_val({loop_en_o, ref_int_o}, {1'b1, mode_o == 3'h0 || mode_o == 3'h2});
      prev = i[3:2] == 2'h3 ? 0 : i[3:2];
      for (int n = 0; n < 400 && stat_o !== prev[1:0]; n++) @(posedge clk_i);
      cmp_val(stat_o, prev);
      rd_chk(CSM_OFS_STAT);
    end
    $display("modes done");
    for (int k = 0; k < 4; k++)
    begin
      wr(CSM_OFS_CTL2, {k[1:0], 6'h02});
      measure(1200);
      cmp_cnt(c_sys, c_osc >> k, 2);
      cmp_cnt(c_bus, c_sys / 2, 1);
      cmp_cnt(c_dbg, c_osc / 2, 1);
    end
    for (int r = 0; r < 8; r++)
    begin
      wr(CSM_OFS_CTL1, {2'h0, r[2:0], 3'h6});
      measure(2000);
      cmp_cnt(c_tick, c_int >> r, 2);
    end
    $display("dividers done");
    wr(CSM_OFS_CTL1, 8'h04);
    measure(300);
    cmp_cnt(c_girc, 0, 0);
    wr(CSM_OFS_CTL1, 8'h07);
    measure(300);
    cmp_cnt(c_girc, c_int, 2);
    stop_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmp_val({mode_o, loop_en_o, int_en_o}, 5'h19);
    measure(300);
    cmp_cnt(c_sys + c_dbg, 0, 0);
    stop_i <= 1'b0;
    wr(CSM_OFS_CTL1, 8'h04);
    stop_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmp_val({int_en_o, ext_en_o}, 2'h0);
    stop_i <= 1'b0;
    wr(CSM_OFS_CTL1, 8'h06);
    repeat (4) @(posedge clk_i);
    cmp_val(mode_o, 3'h0);
    $display("stop done");
    complete_run();
  end
endmodule : fll_clock_source_mode_control_test
`default_nettype wire
